// >>> spi_flash_erase_pkg.sv
// constants and types shared by the erase and identification command logic
package spi_flash_erase_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;
  localparam logic [7:0] OP_MAKER_PART    = 8'h90;
  localparam logic [7:0] OP_IDENT3        = 8'h9f;
  localparam logic [7:0] OP_UNIQUE_ID     = 8'h4b;
  localparam logic [7:0] OP_SECREG_ERASE  = 8'h44;

  // ==========================================================================
  // frame bit counts in rising serial clock edges since select
  localparam logic [7:0] OPCODE_LAST_BIT  = 8'h07;
  localparam logic [7:0] OPCODE_END_BITS  = 8'h08;
  localparam logic [7:0] ADDR_FIRST_BIT   = 8'h08;
  localparam logic [7:0] ADDR_LAST_BIT    = 8'h1f;
  localparam logic [7:0] ADDR_END_BITS    = 8'h20;
  localparam logic [7:0] DUMMY_LAST_BIT   = 8'h27;
  localparam logic [7:0] BIT_COUNT_MAX    = 8'hff;
  localparam int         OUT_SHIFT_W      = 128;
  localparam int         IDENT3_W         = 24;

  // ==========================================================================
  // region address alignment
  localparam int SECTOR_ADDR_BITS  = 12;
  localparam int BLOCK32_ADDR_BITS = 15;
  localparam int BLOCK64_ADDR_BITS = 16;

  // ==========================================================================
  // security register selector fields
  localparam logic [7:0] SECREG_HIGH_SEL = 8'h00;
  localparam logic [3:0] SECREG_SEL_ONE  = 4'h1;
  localparam logic [3:0] SECREG_SEL_THREE = 4'h3;
  localparam logic [2:0] SECREG_MID_SEL  = 3'h0;
  localparam int         SECREG_BYTES    = 512;
  localparam int         SECREG_COUNT    = 3;
  localparam int         SECREG_OFF_W    = 9;
  localparam int         SECREG_IDX_W    = 11;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;

  // ==========================================================================
  // block protect patterns that allow a whole-array erase
  localparam logic [2:0] BP_LOW_NONE = 3'h0;
  localparam logic [2:0] BP_LOW_ALL  = 3'h7;

  // ==========================================================================
  // self-timed erase durations
  localparam int CLK_FREQ_HZ          = 20_000_000;
  localparam int US_PER_S             = 1_000_000;
  localparam int SECTOR_ERASE_TIME_US = 50;
  localparam int BLOCK_ERASE_TIME_US  = 100;
  localparam int CHIP_ERASE_TIME_US   = 200;
  localparam int SECTOR_ERASE_CYCLES  = SECTOR_ERASE_TIME_US * (CLK_FREQ_HZ / US_PER_S);
  localparam int BLOCK_ERASE_CYCLES   = BLOCK_ERASE_TIME_US * (CLK_FREQ_HZ / US_PER_S);
  localparam int CHIP_ERASE_CYCLES    = CHIP_ERASE_TIME_US * (CLK_FREQ_HZ / US_PER_S);
  localparam int TIMER_W              = 16;

  // ==========================================================================
  // reset values
  localparam logic WEL_RESET = 1'b0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ERASE_NONE    = 3'b000,
    ERASE_SECTOR  = 3'b001,
    ERASE_BLOCK32 = 3'b010,
    ERASE_BLOCK64 = 3'b011,
    ERASE_CHIP    = 3'b100,
    ERASE_SECREG  = 3'b101
  } erase_kind_t;

  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_ERASING = 1'b1
  } erase_state_t;

endpackage

// >>> pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rstn,
  // pins and their synchronised copies
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_reset_level,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // one chain per bit; stage1 feeds nothing but the second flop
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
        stage1[b] <= i_reset_level[b];
        o_sync[b] <= i_reset_level[b];
      end else begin
        stage1[b] <= i_async[b];
        o_sync[b] <= stage1[b];
      end
    end
  end

endmodule

// >>> spi_flash_erase_and_id_cmds.sv
// erase, identification and security register erase command logic
`timescale 1ns/1ps
module spi_flash_erase_and_id_cmds
  import spi_flash_erase_pkg::*;
#(
  parameter int          SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int          BLOCK_CYCLES  = BLOCK_ERASE_CYCLES,
  parameter int          CHIP_CYCLES   = CHIP_ERASE_CYCLES,
  parameter logic [7:0]  MAKER_CODE    = 8'h5a,          // arbitrary value
  parameter logic [7:0]  PART_CODE     = 8'h13,          // arbitrary value
  parameter logic [7:0]  MEM_TYPE      = 8'h40,          // arbitrary value
  parameter logic [7:0]  CAPACITY      = 8'h15,          // arbitrary value
  parameter logic [127:0] UNIQUE_ID    = 128'h0123456789abcdef0f1e2d3c4b5a6978 // arbitrary
) (
  // clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rstn,
  // serial link pins
  input  wire logic                    i_spi_cs_n,
  input  wire logic                    i_spi_sclk,
  input  wire logic                    i_spi_si,
  output logic                         o_spi_so,
  output logic                         o_spi_so_en,
  // status and protection
  input  wire logic                    i_write_enable_command,
  input  wire logic                    i_program_busy,
  input  wire logic [4:0]              i_block_protect,
  input  wire logic                    i_protect_complement,
  input  wire logic                    i_otp_lock_bit_one,
  input  wire logic                    i_frame_addr_protected,
  output logic                         o_write_enable_latch,
  output logic                         o_write_in_progress,
  // erase request toward the array
  output logic [23:0]                  o_frame_addr,
  output logic                         o_erase_start,
  output erase_kind_t                  o_erase_kind,
  output logic [23:0]                  o_erase_addr,
  // security register program and read port
  input  wire logic                    i_secreg_prog_en,
  input  wire logic [SECREG_IDX_W-1:0] i_secreg_prog_addr,
  input  wire logic [7:0]              i_secreg_prog_data,
  input  wire logic [SECREG_IDX_W-1:0] i_secreg_rd_addr,
  output logic [7:0]                   o_secreg_rd_data
);

  // ==========================================================================
  // pin synchronisation and edge detection
  logic [2:0] pins_sync;
  logic       cs_n_s;
  logic       sclk_s;
  logic       si_s;
  logic       cs_n_q;
  logic       sclk_q;

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .i_clk_sys     (i_clk_sys),
    .i_rstn        (i_rstn),
    .i_async       ({i_spi_cs_n, i_spi_sclk, i_spi_si}),
    .i_reset_level (3'h4),
    .o_sync        (pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign si_s   = pins_sync[0];

  // delayed copies; the chain starts deselected so no false select edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  // edges only count while selected
  assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
  assign cs_rise   = cs_n_s & ~cs_n_q;

  // ==========================================================================
  // frame capture: opcode, address, bit count
  logic [7:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  next_opcode_bits;
  logic [23:0] next_addr_bits;

  assign next_opcode_bits = {shreg[6:0], si_s};
  assign next_addr_bits   = {addr[22:0], si_s};

  // msb first, counting from the select fall
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || cs_n_s) begin
      bit_cnt <= 8'h00;
      shreg   <= 8'h00;
    end else if (sclk_rise) begin
      shreg   <= next_opcode_bits;
      bit_cnt <= (bit_cnt == BIT_COUNT_MAX) ? bit_cnt : bit_cnt + 8'h01;
    end
  end

  // opcode and address hold past the select rise for the accept check
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      opcode <= 8'h00;
      addr   <= 24'h000000;
    end else if (sclk_rise && bit_cnt == OPCODE_LAST_BIT) begin
      opcode <= next_opcode_bits;
    end else if (sclk_rise && bit_cnt >= ADDR_FIRST_BIT && bit_cnt <= ADDR_LAST_BIT) begin
      addr   <= next_addr_bits;
    end
  end

  assign o_frame_addr = addr;

  // ==========================================================================
  // erase decode and acceptance
  erase_kind_t       kind;
  erase_state_t      state;
  logic              busy;
  logic              write_enable_latch;
  logic              is_chip_op;
  logic              secreg_sel_ok;
  logic              chip_prot_ok;
  logic              frame_len_ok;
  logic              kind_permitted;
  logic              accept;
  logic [1:0]        secreg_sel;
  logic [23:0]       erase_base;
  logic [TIMER_W-1:0] duration;

  assign busy       = (state == ST_ERASING);
  assign is_chip_op = (opcode == OP_CHIP_ERASE_A) || (opcode == OP_CHIP_ERASE_B);

  // opcode to erase kind
  assign kind = (opcode == OP_SECTOR_ERASE)  ? ERASE_SECTOR :
                (opcode == OP_BLOCK32_ERASE) ? ERASE_BLOCK32 :
                (opcode == OP_BLOCK64_ERASE) ? ERASE_BLOCK64 :
                is_chip_op                   ? ERASE_CHIP :
                (opcode == OP_SECREG_ERASE)  ? ERASE_SECREG :
                                               ERASE_NONE;

  // select must rise right after the frame's last byte
  assign frame_len_ok = (kind == ERASE_CHIP) ? (bit_cnt == OPCODE_END_BITS) :
                                               (bit_cnt == ADDR_END_BITS);

  // security register selector; low nine bits ignored
  assign secreg_sel_ok = (addr[23:16] == SECREG_HIGH_SEL) &&
                         (addr[15:12] >= SECREG_SEL_ONE) &&
                         (addr[15:12] <= SECREG_SEL_THREE) &&
                         (addr[11:9] == SECREG_MID_SEL);
  assign secreg_sel    = 2'(addr[13:12] - 2'h1);

  // whole-array erase looks only at the three low protect bits and the complement bit
  assign chip_prot_ok = ((i_block_protect[2:0] == BP_LOW_NONE) && !i_protect_complement) ||
                        ((i_block_protect[2:0] == BP_LOW_ALL) && i_protect_complement);

  // per-kind protection; region protect comes from outside
  assign kind_permitted = (kind == ERASE_CHIP)   ? chip_prot_ok :
                          (kind == ERASE_SECREG) ? secreg_sel_ok && !i_otp_lock_bit_one :
                          (kind != ERASE_NONE)   ? !i_frame_addr_protected :
                                                   1'b0;

  // relies on the host holding select low through the address
  assign accept = cs_rise && frame_len_ok && kind_permitted && write_enable_latch &&
                  !busy && !i_program_busy;

  // region base, in-region address bits cleared
  assign erase_base =
    (kind == ERASE_SECTOR)  ? {addr[23:SECTOR_ADDR_BITS], {SECTOR_ADDR_BITS{1'b0}}} :
    (kind == ERASE_BLOCK32) ? {addr[23:BLOCK32_ADDR_BITS], {BLOCK32_ADDR_BITS{1'b0}}} :
    (kind == ERASE_BLOCK64) ? {addr[23:BLOCK64_ADDR_BITS], {BLOCK64_ADDR_BITS{1'b0}}} :
    (kind == ERASE_SECREG)  ? {addr[23:SECREG_OFF_W], {SECREG_OFF_W{1'b0}}} :
                              24'h000000;

  // security register wipe shares the sector duration
  assign duration = (kind == ERASE_CHIP)   ? TIMER_W'(CHIP_CYCLES - 1) :
                    (kind == ERASE_BLOCK32 || kind == ERASE_BLOCK64) ?
                                             TIMER_W'(BLOCK_CYCLES - 1) :
                                             TIMER_W'(SECTOR_CYCLES - 1);

  // ==========================================================================
  // self-timed erase
  logic [TIMER_W-1:0]    timer;
  logic [SECREG_OFF_W:0] wipe_idx;
  logic [1:0]            wipe_sel;
  logic                  wiping;

  // wipe walks one byte per cycle; durations are far above 512 cycles
  assign wiping = busy && (o_erase_kind == ERASE_SECREG) && !wipe_idx[SECREG_OFF_W];

  // idle until accepted, then count down to the end of the cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state         <= ST_IDLE;
      timer         <= '0;
      o_erase_start <= 1'b0;
      o_erase_kind  <= ERASE_NONE;
      o_erase_addr  <= 24'h000000;
      wipe_idx      <= '0;
      wipe_sel      <= 2'h0;
    end else begin
      o_erase_start <= accept;
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state        <= ST_ERASING;
            timer        <= duration;
            o_erase_kind <= kind;
            o_erase_addr <= erase_base;
            wipe_idx     <= '0;
            wipe_sel     <= secreg_sel;
          end
        end
        ST_ERASING: begin
          if (timer == '0) begin
            state <= ST_IDLE;
          end else begin
            timer <= timer - TIMER_W'(1);
          end
          if (wiping) begin
            wipe_idx <= wipe_idx + 10'h001;
          end
        end
      endcase
    end
  end

  assign o_write_in_progress = busy;

  // latch clears when the erase starts; a set in the same cycle wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      write_enable_latch <= WEL_RESET;
    end else if (i_write_enable_command) begin
      write_enable_latch <= 1'b1;
    end else if (accept) begin
      write_enable_latch <= 1'b0;
    end
  end

  assign o_write_enable_latch = write_enable_latch;

  // ==========================================================================
  // security register storage: three pages of 512 bytes
  logic [7:0] secreg_mem [0:SECREG_COUNT*SECREG_BYTES-1];
  logic       prog_ok;

  // programming only clears bits and stays out while locked or erasing
  assign prog_ok = i_secreg_prog_en && !i_otp_lock_bit_one && !busy &&
                   (i_secreg_prog_addr[SECREG_IDX_W-1 -: 2] != 2'h3);

  // nonvolatile contents, so no reset on the array
  always_ff @(posedge i_clk_sys) begin
    if (wiping) begin
      secreg_mem[{wipe_sel, wipe_idx[SECREG_OFF_W-1:0]}] <= ERASED_BYTE;
    end else if (prog_ok) begin
      secreg_mem[i_secreg_prog_addr] <= secreg_mem[i_secreg_prog_addr] & i_secreg_prog_data;
    end
  end

  // registered read port
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_secreg_rd_data <= 8'h00;
    end else begin
      o_secreg_rd_data <= secreg_mem[i_secreg_rd_addr];
    end
  end

  // ==========================================================================
  // identification output
  logic [OUT_SHIFT_W-1:0] out_sr;
  logic                   out_active;
  logic                   load_ident3;
  logic                   load_maker;
  logic                   load_unique;
  logic [OUT_SHIFT_W-1:0] load_word;

  // ident opcode undecoded while a cycle runs
  assign load_ident3 = sclk_rise && bit_cnt == OPCODE_LAST_BIT &&
                       next_opcode_bits == OP_IDENT3 && !busy && !i_program_busy;
  assign load_maker  = sclk_rise && bit_cnt == ADDR_LAST_BIT &&
                       opcode == OP_MAKER_PART && next_addr_bits == 24'h000000;
  assign load_unique = sclk_rise && bit_cnt == DUMMY_LAST_BIT &&
                       opcode == OP_UNIQUE_ID && addr == 24'h000000;

  // maker/part pair repeats eight times, then zeros follow
  assign load_word = load_ident3 ? {MAKER_CODE, MEM_TYPE, CAPACITY,
                                    {(OUT_SHIFT_W - IDENT3_W){1'b0}}} :
                     load_maker  ? {8{MAKER_CODE, PART_CODE}} :
                                   UNIQUE_ID;

  // msb first on falling edges; select rise stops output
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || cs_n_s) begin
      out_sr      <= '0;
      out_active  <= 1'b0;
      o_spi_so    <= 1'b0;
      o_spi_so_en <= 1'b0;
    end else if (load_ident3 || load_maker || load_unique) begin
      out_sr      <= load_word;
      out_active  <= 1'b1;
    end else if (sclk_fall && out_active) begin
      o_spi_so    <= out_sr[OUT_SHIFT_W-1];
      o_spi_so_en <= 1'b1;
      out_sr      <= {out_sr[OUT_SHIFT_W-2:0], 1'b0};
    end
  end

  // upper protect bits feed outside region protect logic, not this block
  logic unused_bp_high;
  assign unused_bp_high = ^i_block_protect[4:3];

endmodule

// >>> spi_flash_erase_sva.sv
// concurrent checks on the erase and ident command block ports
`timescale 1ns/1ps
module spi_flash_erase_sva
  import spi_flash_erase_pkg::*;
(
  // clock, reset and inputs
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_spi_cs_n,
  input wire logic [4:0]  i_block_protect,
  input wire logic        i_protect_complement,
  input wire logic        i_otp_lock_bit_one,
  input wire logic        i_frame_addr_protected,
  // outputs under watch
  input wire logic        o_spi_so,
  input wire logic        o_spi_so_en,
  input wire logic        o_write_enable_latch,
  input wire logic        o_write_in_progress,
  input wire logic        o_erase_start,
  input wire erase_kind_t o_erase_kind,
  input wire logic [23:0] o_erase_addr
);
  // low bits each kind's base must clear
  wire logic [23:0] mask = (o_erase_kind == ERASE_SECTOR)  ? 24'h000fff :
                           (o_erase_kind == ERASE_BLOCK32) ? 24'h007fff :
                           (o_erase_kind == ERASE_BLOCK64) ? 24'h00ffff :
                           (o_erase_kind == ERASE_SECREG)  ? 24'h0001ff : 24'hffffff;
  // ==========================================================================
  // launch and output checks; $past sees the accept cycle
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_start_sets_busy: assert property (
    o_erase_start |-> o_write_in_progress && !o_write_enable_latch)
    else $error("start without busy or latch clear");
  a_start_one_pulse: assert property (
    o_erase_start |=> !o_erase_start)
    else $error("erase start longer than one cycle");
  a_start_needs_latch: assert property (
    o_erase_start |-> $past(o_write_enable_latch) && !$past(o_write_in_progress))
    else $error("erase without latch or while busy");
  a_busy_from_start: assert property (
    $rose(o_write_in_progress) |-> o_erase_start)
    else $error("busy rose without an erase start");
  a_base_aligned: assert property (
    o_erase_start |-> (o_erase_addr & mask) == 24'h000000)
    else $error("erase base not aligned to its region");
  a_chip_protect: assert property (
    o_erase_start && o_erase_kind == ERASE_CHIP |->
      ($past(i_block_protect[2:0]) == BP_LOW_NONE && !$past(i_protect_complement)) ||
      ($past(i_block_protect[2:0]) == BP_LOW_ALL && $past(i_protect_complement)))
    else $error("chip erase started under protection");
  a_area_protect: assert property (
    o_erase_start && o_erase_kind inside {ERASE_SECTOR, ERASE_BLOCK32, ERASE_BLOCK64}
      |-> !$past(i_frame_addr_protected))
    else $error("erase on a protected area");
  a_secreg_select: assert property (
    o_erase_start && o_erase_kind == ERASE_SECREG |-> !$past(i_otp_lock_bit_one) &&
      o_erase_addr[23:16] == SECREG_HIGH_SEL && o_erase_addr[11:9] == SECREG_MID_SEL &&
      o_erase_addr[15:12] inside {[SECREG_SEL_ONE:SECREG_SEL_THREE]})
    else $error("bad security register erase");
  a_out_idle: assert property (
    i_spi_cs_n [*4] |=> !o_spi_so_en && !o_spi_so)
    else $error("output driven while deselected");
endmodule
bind spi_flash_erase_and_id_cmds spi_flash_erase_sva u_sva (
  .i_clk_sys, .i_rstn, .i_spi_cs_n, .i_block_protect, .i_protect_complement,
  .i_otp_lock_bit_one, .i_frame_addr_protected, .o_spi_so, .o_spi_so_en,
  .o_write_enable_latch, .o_write_in_progress, .o_erase_start, .o_erase_kind, .o_erase_addr);

// >>> spi_host_model.sv
// host serial controller model driving the link pins
`timescale 1ns/1ps
module spi_host_model (
  // link pins
  output logic      o_cs_n,
  output logic      o_sclk,
  input  wire logic i_so,
  output logic      o_si
);
  // idle link: deselected, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b1;
  end
  // one frame; deep power-down is never entered
  task automatic xfer(input logic [39:0] tx, input int nb, input int nr,
                      output logic [127:0] rx);
    rx = '0;
    #800 o_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      o_si = tx[39-i];
      #200 o_sclk = 1'b1;
      #200 o_sclk = 1'b0;
    end
    // read phase; sample late, the bit lands cycles after the fall
    for (int i = 0; i < nr; i++) begin
      o_si = ~o_si;
      #200 o_sclk = 1'b1;
      #100 rx = {rx[126:0], i_so};
      #100 o_sclk = 1'b0;
    end
    #200 o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule

// >>> tb.sv
// self-checking bench for the erase and ident command block
`timescale 1ns/1ps
module tb;
  import spi_flash_erase_pkg::*;
  localparam int           SEC_N = 520;
  localparam int           BLK_N = 600;
  localparam logic [7:0]   MAKER = 8'ha7; // arbitrary value
  localparam logic [7:0]   PART  = 8'h3e; // arbitrary value
  localparam logic [7:0]   MTYPE = 8'h61; // arbitrary value
  localparam logic [7:0]   CAP   = 8'h2c; // arbitrary value
  localparam logic [127:0] UID   = 128'hfedcba98765432100123456789abcdef; // arbitrary value
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  nb;
    logic [5:0]  prot; // lock, area protect, complement, low protect bits
    erase_kind_t kind; // none where the frame must be dropped
    logic [23:0] base;
    int          cyc;
  } row_t;
  logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_write_enable_command = 1'b0, i_program_busy = 1'b0;
  logic i_protect_complement = 1'b0, i_otp_lock_bit_one = 1'b0, i_frame_addr_protected = 1'b0;
  logic i_secreg_prog_en = 1'b0, i_spi_cs_n, i_spi_sclk, i_spi_si, o_spi_so, o_spi_so_en;
  logic o_write_enable_latch, o_write_in_progress, o_erase_start, seen, en_seen = 1'b0;
  logic [4:0]   i_block_protect = 5'h00;
  logic [10:0]  i_secreg_prog_addr = 11'h000, i_secreg_rd_addr = 11'h000;
  logic [7:0]   i_secreg_prog_data = 8'h00, o_secreg_rd_data;
  logic [23:0]  o_frame_addr, o_erase_addr;
  logic [127:0] rx;
  erase_kind_t  o_erase_kind;
  int           n, n_fail = 0, num_checks = 0;
  // refused first, accepted last so the latch ends clear
  row_t rows [16] = '{
    '{OP_SECTOR_ERASE, 24'h123456, 8'h1f, 6'h00, ERASE_NONE, 24'h0, 0},
    '{OP_CHIP_ERASE_A, 24'h000000, 8'h10, 6'h00, ERASE_NONE, 24'h0, 0},
    '{OP_CHIP_ERASE_B, 24'h000000, 8'h08, 6'h01, ERASE_NONE, 24'h0, 0},
    '{OP_CHIP_ERASE_A, 24'h000000, 8'h08, 6'h08, ERASE_NONE, 24'h0, 0},
    '{OP_SECTOR_ERASE, 24'h123456, 8'h20, 6'h10, ERASE_NONE, 24'h0, 0},
    '{OP_BLOCK32_ERASE, 24'h123456, 8'h20, 6'h10, ERASE_NONE, 24'h0, 0},
    '{OP_SECREG_ERASE, 24'h004000, 8'h20, 6'h00, ERASE_NONE, 24'h0, 0},
    '{OP_SECREG_ERASE, 24'h001200, 8'h20, 6'h00, ERASE_NONE, 24'h0, 0},
    '{OP_SECTOR_ERASE, 24'h123456, 8'h20, 6'h00, ERASE_SECTOR, 24'h123000, SEC_N},
    '{OP_BLOCK32_ERASE, 24'h12ffff, 8'h20, 6'h00, ERASE_BLOCK32, 24'h128000, BLK_N},
    '{OP_BLOCK64_ERASE, 24'h12ffff, 8'h20, 6'h00, ERASE_BLOCK64, 24'h120000, BLK_N},
    '{OP_CHIP_ERASE_A, 24'h000000, 8'h08, 6'h00, ERASE_CHIP, 24'h0, BLK_N},
    '{OP_CHIP_ERASE_B, 24'h000000, 8'h08, 6'h0f, ERASE_CHIP, 24'h0, BLK_N},
    '{OP_SECREG_ERASE, 24'h0011ff, 8'h20, 6'h00, ERASE_SECREG, 24'h001000, SEC_N},
    '{OP_SECREG_ERASE, 24'h0021ff, 8'h20, 6'h00, ERASE_SECREG, 24'h002000, SEC_N},
    '{OP_SECREG_ERASE, 24'h003000, 8'h20, 6'h00, ERASE_SECREG, 24'h003000, SEC_N}};
  // ==========================================================================
  // design, host, clock and output monitor
  spi_flash_erase_and_id_cmds #(.SECTOR_CYCLES(SEC_N), .BLOCK_CYCLES(BLK_N),
    .CHIP_CYCLES(BLK_N), .MAKER_CODE(MAKER), .PART_CODE(PART), .MEM_TYPE(MTYPE),
    .CAPACITY(CAP), .UNIQUE_ID(UID)) u_spi_flash_erase_and_id_cmds (.i_clk_sys, .i_rstn,
    .i_spi_cs_n, .i_spi_sclk, .i_spi_si, .o_spi_so, .o_spi_so_en, .i_write_enable_command,
    .i_program_busy, .i_block_protect, .i_protect_complement, .i_otp_lock_bit_one,
    .i_frame_addr_protected, .o_write_enable_latch, .o_write_in_progress, .o_frame_addr,
    .o_erase_start, .o_erase_kind, .o_erase_addr, .i_secreg_prog_en, .i_secreg_prog_addr,
    .i_secreg_prog_data, .i_secreg_rd_addr, .o_secreg_rd_data);
  spi_host_model u_spi_host_model (.o_cs_n(i_spi_cs_n), .o_sclk(i_spi_sclk),
    .i_so(o_spi_so), .o_si(i_spi_si));
  always #25 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (o_spi_so_en) en_seen <= 1'b1;
  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pulse_wen;
    @(negedge i_clk_sys) i_write_enable_command = 1'b1;
    @(negedge i_clk_sys) i_write_enable_command = 1'b0;
  endtask
  // one frame, then a bounded wait for the start pulse
  task automatic erase(input logic [7:0] op, input logic [23:0] a, input logic [7:0] nb);
    u_spi_host_model.xfer({op, a, 8'h00}, nb, 0, rx);
    seen = 1'b0;
    for (int j = 0; j < 20 && !seen; j++) @(negedge i_clk_sys) seen = o_erase_start;
  endtask
  task automatic wait_idle;
    for (n = 0; o_write_in_progress === 1'b1 && n < 5000; n++) @(negedge i_clk_sys);
  endtask
  task automatic sec_rd(input logic [10:0] a, input logic [7:0] exp);
    @(negedge i_clk_sys) i_secreg_rd_addr = a;
    @(negedge i_clk_sys) chk("secreg data", o_secreg_rd_data, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(negedge i_clk_sys);
    chk("reset outputs", {o_write_enable_latch, o_write_in_progress, o_spi_so_en}, 3'h0);
    i_rstn = 1'b1;
    repeat (5) @(negedge i_clk_sys);
    foreach (rows[k]) begin
      @(negedge i_clk_sys) {i_otp_lock_bit_one, i_frame_addr_protected, i_protect_complement,
        i_block_protect[2:0]} = rows[k].prot;
      pulse_wen;
      chk("latch set", o_write_enable_latch, 1'b1);
      erase(rows[k].op, rows[k].addr, rows[k].nb);
      chk("start", seen, rows[k].kind != ERASE_NONE);
      if (rows[k].nb == 8'h20) chk("frame addr", o_frame_addr, rows[k].addr);
      if (seen) begin
        chk("kind", o_erase_kind, rows[k].kind);
        chk("base", o_erase_addr, rows[k].base);
        chk("latch clear", o_write_enable_latch, 1'b0);
        wait_idle;
        chk("busy cycles", n, rows[k].cyc);
      end
    end
    $display("erase table done");
    erase(OP_SECTOR_ERASE, 24'h000000, 8'h20);
    chk("unlatched erase", seen, 1'b0);
    sec_rd(11'h3ff, 8'hff);
    @(negedge i_clk_sys) {i_secreg_prog_en, i_secreg_prog_addr, i_secreg_prog_data} = 20'ha013c;
    @(negedge i_clk_sys) i_secreg_prog_en = 1'b0;
    sec_rd(11'h201, 8'h3c);
    sec_rd(11'h001, 8'hff);
    i_otp_lock_bit_one = 1'b1;
    pulse_wen;
    erase(OP_SECREG_ERASE, 24'h002000, 8'h20);
    chk("locked erase", seen, 1'b0);
    sec_rd(11'h201, 8'h3c);
    i_otp_lock_bit_one = 1'b0;
    $display("security register tests done");
    u_spi_host_model.xfer({OP_IDENT3, 32'h0}, 8, 24, rx);
    chk("ident3", rx, {MAKER, MTYPE, CAP});
    u_spi_host_model.xfer({OP_MAKER_PART, 32'h0}, 32, 16, rx);
    chk("maker part", rx, {MAKER, PART});
    u_spi_host_model.xfer({OP_UNIQUE_ID, 32'h0}, 40, 128, rx);
    chk("unique id", rx, UID);
    u_spi_host_model.xfer({OP_IDENT3, 32'h0}, 8, 5, rx);
    chk("cut ident", rx, MAKER[7:3]);
    repeat (10) @(negedge i_clk_sys);
    chk("drive off", o_spi_so_en, 1'b0);
    erase(OP_SECTOR_ERASE, 24'h000000, 8'h20);
    en_seen = 1'b0;
    u_spi_host_model.xfer({OP_IDENT3, 32'h0}, 8, 24, rx);
    chk("ident while busy", en_seen, 1'b0);
    chk("busy kept", o_write_in_progress, 1'b1);
    wait_idle;
    $display("identification tests done");
    end_of_test;
  end
  // hang guard, over twice the sequence length
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    chk("watchdog", 1'b0, 1'b1);
    end_of_test;
  end
endmodule
